// >>> rtl/continuous_io_report_engine.sv
`timescale 1ns/1ps
module continuous_io_report_engine import report_pkg::*; #(
   parameter int LINES = LINES_DEF,
   parameter int ADDR_W = 8,
   parameter int TICK_CYC = TICK_CYCLES,
   parameter int TRIG_CYC = TRIG_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // AXI4-Lite slave
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Serial character stream to and from the line UART
   output logic [7:0] tx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   // Digital I/O lines, line 0 doubles as edge_trigger_in
   input wire logic [LINES-1:0] io_in,
   output logic [LINES-1:0] io_out,
   output logic [LINES-1:0] io_oe,
   // Open-drain trigger_out pin
   output logic trig_o,
   output logic trig_oe
);
   localparam int TICK_W = $clog2(TICK_CYC + 1);
   localparam int TRIG_W = $clog2(TRIG_CYC + 1);

   logic rst_meta, rst_n;
   logic [LINES-1:0] io_s1, io_s2;
   logic edge_prev;
   logic [ADDR_W-1:0] waddr;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic aw_have, w_have, wr_en;
   logic [31:0] wr_word;
   mode_t mode_reg;
   logic [15:0] ct_reg, wait_cnt, rx_count;
   logic [7:0] own_addr, cia_reg;
   state_t state, next_state;
   logic [TICK_W-1:0] tick_cnt;
   logic tick;
   logic [TRIG_W-1:0] trig_cnt;
   logic [DATA_W-1:0] io_word, oe_word, last_rep, snap;
   logic [3:0] send_idx, rx_idx;
   logic [7:0] sum, sum_nxt, rx_sum;
   logic [DATA_W-1:0] rx_word;
   logic rx_ok, rx_good, rx_accept;
   logic [4:0] rx_hex;
   logic edge_rise, in_changed, ct_zero, start_send, str_done, tx_hs;

   // Hex nibble to ASCII character
   function automatic logic [7:0] hex_char(input logic [3:0] n);
      return (n < 4'ha) ? (CHAR_0 + {4'h0, n}) : (HEX_LETTER_BASE + {4'h0, n});
   endfunction

   // ASCII character to {valid, nibble}
   function automatic logic [4:0] hex_val(input logic [7:0] c);
      logic [7:0] d;
      d = 8'h00;
      if (c >= CHAR_0 && c <= CHAR_9) begin
         d = c - CHAR_0;
         return {1'b1, d[3:0]};
      end
      if (c >= CHAR_A && c <= CHAR_F) begin
         d = c - HEX_LETTER_BASE;
         return {1'b1, d[3:0]};
      end
      return 5'h00;
   endfunction

   // Character at a given position of a report string
   function automatic logic [7:0] char_at(input logic [3:0] i, input logic [7:0] a,
                                          input logic [15:0] d, input logic [7:0] c);
      case (i)
         4'h0: return CHAR_STAR;
         4'h1: return a;
         4'h2: return CHAR_D;
         4'h3: return CHAR_I;
         4'h4: return hex_char(d[15:12]);
         4'h5: return hex_char(d[11:8]);
         4'h6: return hex_char(d[7:4]);
         4'h7: return hex_char(d[3:0]);
         4'h8: return hex_char(c[7:4]);
         4'h9: return hex_char(c[3:0]);
         default: return CHAR_CR;
      endcase
   endfunction

   // Register word at an address, zero where unmapped
   function automatic logic [31:0] reg_word(input logic [ADDR_W-1:0] a);
      case (8'(a))
         REG_MODE: return {29'h0, mode_reg};
         REG_TIMER: return {16'h0, ct_reg};
         REG_ADDR: return {16'h0, cia_reg, own_addr};
         REG_DIR: return {16'h0, oe_word};
         REG_STATUS: return {14'h0, trig_oe, (state != S_IDLE), io_word};
         REG_RXCNT: return {16'h0, rx_count};
         default: return 32'h0;
      endcase
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return (8'(a) <= REG_RXCNT) && (a[1:0] == 2'b00);
   endfunction

   // Reset release through two flops
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // Pin synchronisers and edge history
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         io_s1 <= '0;
         io_s2 <= '0;
         edge_prev <= 1'b0;
      end else begin
         io_s1 <= io_in;
         io_s2 <= io_s1;
         edge_prev <= io_s2[0];
      end
   end

   assign io_word = {{(DATA_W-LINES){1'b0}}, io_s2};
   assign oe_word = {{(DATA_W-LINES){1'b0}}, io_oe};
   assign edge_rise = io_s2[0] && !edge_prev;
   assign in_changed = |((io_word ^ last_rep) & ~oe_word);
   assign ct_zero = (ct_reg == 16'h0);
   assign tx_hs = tx_valid && tx_ready;
   assign str_done = (state == S_SEND) && tx_hs && (send_idx == IDX_LAST);
   assign start_send = (state != S_SEND) && (next_state == S_SEND);

   // AXI write channel: address and data taken in either order
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_have <= 1'b0;
         w_have <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         waddr <= '0;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have <= 1'b1;
            s_axi_awready <= 1'b0;
            waddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have <= 1'b1;
            s_axi_wready <= 1'b0;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_en) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(waddr) ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_have <= 1'b0;
            w_have <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   assign wr_en = aw_have && w_have && !s_axi_bvalid;

   // Byte-lane merge of the write data into the current word
   always_comb begin
      wr_word = reg_word(waddr);
      for (int b = 0; b < 4; b++) begin
         if (wstrb_q[b]) begin
            wr_word[b*8 +: 8] = wdata_q[b*8 +: 8];
         end
      end
   end

   // AXI read channel
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= reg_word(s_axi_araddr);
         s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Mode commands; an unknown code disables continuous operation
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_reg <= MODE_OFF;
      end else if (wr_en && 8'(waddr) == REG_MODE) begin
         case (wr_word[2:0])
            MODE_TIMER: mode_reg <= MODE_TIMER;
            MODE_EDGE: mode_reg <= MODE_EDGE;
            MODE_CHANGE: mode_reg <= MODE_CHANGE;
            MODE_INPUT: mode_reg <= MODE_INPUT;
            default: mode_reg <= MODE_OFF;
         endcase
      end
   end

   // Timer, addresses and direction registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ct_reg <= TIMER_RESET;
         own_addr <= OWN_ADDR_RESET;
         cia_reg <= CIA_RESET;
         io_oe <= DIR_RESET[LINES-1:0];
      end else if (wr_en) begin
         if (8'(waddr) == REG_TIMER) ct_reg <= wr_word[15:0];
         if (8'(waddr) == REG_ADDR) begin
            own_addr <= wr_word[7:0];
            cia_reg <= wr_word[15:8];
         end
         if (8'(waddr) == REG_DIR) io_oe <= wr_word[LINES-1:0];
      end
   end

   // Timer tick divider, one pulse per timer unit
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt <= '0;
         tick <= 1'b0;
      end else begin
         tick <= (tick_cnt == TICK_W'(TICK_CYC - 1));
         tick_cnt <= (tick_cnt == TICK_W'(TICK_CYC - 1)) ? '0 : tick_cnt + 1'b1;
      end
   end

   // Report sequencer
   always_comb begin
      next_state = state;
      case (state)
         S_IDLE: begin
            case (mode_reg)
               MODE_TIMER: next_state = ct_zero ? S_SEND : S_DELAY;
               MODE_EDGE: if (edge_rise) next_state = ct_zero ? S_SEND : S_DELAY;
               MODE_CHANGE: if (in_changed) next_state = S_SEND;
               default: next_state = S_IDLE;
            endcase
         end
         S_DELAY: begin
            if (mode_reg != MODE_TIMER && mode_reg != MODE_EDGE) next_state = S_IDLE;
            else if (wait_cnt == 16'h0) next_state = S_SEND;
         end
         S_SEND: begin
            if (str_done) next_state = (mode_reg == MODE_CHANGE && !ct_zero) ? S_DEAD : S_IDLE;
         end
         S_DEAD: begin
            if (mode_reg != MODE_CHANGE || wait_cnt == 16'h0) next_state = S_IDLE;
         end
         default: next_state = S_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) state <= S_IDLE;
      else state <= next_state;
   end

   // Delay and dead-time counter in timer units
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_cnt <= 16'h0;
      end else if ((state != S_DELAY && next_state == S_DELAY) || next_state == S_DEAD && state == S_SEND) begin
         wait_cnt <= ct_reg;
      end else if (tick && wait_cnt != 16'h0) begin
         wait_cnt <= wait_cnt - 16'h1;
      end
   end

   // Last reported input state; tracks the lines outside change mode
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) last_rep <= '0;
      else if (start_send || mode_reg != MODE_CHANGE) last_rep <= io_word;
   end

   assign sum_nxt = (send_idx < IDX_CKS_HI) ? sum + tx_data : sum;

   // Character transmitter
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_valid <= 1'b0;
         tx_data <= 8'h00;
         send_idx <= 4'h0;
         sum <= 8'h00;
         snap <= '0;
      end else if (start_send) begin
         snap <= io_word;
         send_idx <= 4'h0;
         sum <= 8'h00;
         tx_valid <= 1'b1;
         tx_data <= CHAR_STAR;
      end else if (tx_hs) begin
         if (send_idx == IDX_LAST) begin
            tx_valid <= 1'b0;
         end else begin
            send_idx <= send_idx + 4'h1;
            sum <= sum_nxt;
            tx_data <= char_at(send_idx + 4'h1, own_addr, snap, sum_nxt);
         end
      end
   end

   // Trigger pulse after every completed string
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         trig_oe <= 1'b0;
         trig_o <= 1'b0;
         trig_cnt <= '0;
      end else if (str_done) begin
         trig_oe <= 1'b1;
         trig_cnt <= TRIG_W'(TRIG_CYC - 1);
      end else if (trig_oe) begin
         if (trig_cnt == '0) trig_oe <= 1'b0;
         else trig_cnt <= trig_cnt - 1'b1;
      end
   end

   // Receive parser for foreign reports
   assign rx_hex = hex_val(rx_data);
   always_comb begin
      case (rx_idx)
         4'h1: rx_good = (rx_data == cia_reg);
         4'h2: rx_good = (rx_data == CHAR_D);
         4'h3: rx_good = (rx_data == CHAR_I);
         4'h4, 4'h5, 4'h6, 4'h7: rx_good = rx_hex[4];
         4'h8: rx_good = rx_hex[4] && (rx_hex[3:0] == rx_sum[7:4]);
         4'h9: rx_good = rx_hex[4] && (rx_hex[3:0] == rx_sum[3:0]);
         4'ha: rx_good = (rx_data == CHAR_CR);
         default: rx_good = 1'b0;
      endcase
   end
   assign rx_accept = rx_valid && rx_ok && rx_good && rx_idx == IDX_LAST && mode_reg == MODE_INPUT;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_idx <= 4'h0;
         rx_ok <= 1'b0;
         rx_sum <= 8'h00;
         rx_word <= '0;
      end else if (rx_valid) begin
         if (rx_data == CHAR_STAR) begin
            rx_idx <= IDX_ADDR;
            rx_ok <= 1'b1;
            rx_sum <= CHAR_STAR;
         end else if (rx_ok) begin
            rx_ok <= rx_good && rx_idx != IDX_LAST;
            rx_idx <= rx_idx + 4'h1;
            if (rx_idx < IDX_CKS_HI) rx_sum <= rx_sum + rx_data;
            if (rx_idx > 4'h3 && rx_idx < IDX_CKS_HI) rx_word <= {rx_word[DATA_W-5:0], rx_hex[3:0]};
         end
      end
   end

   // Output lines follow accepted reports, inverted
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         io_out <= '0;
         rx_count <= 16'h0;
      end else if (rx_accept) begin
         io_out <= ~rx_word[LINES-1:0];
         rx_count <= rx_count + 16'h1;
      end
   end

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence s_str_done;
      state == S_SEND && tx_hs && send_idx == IDX_LAST;
   endsequence
   sequence s_pulse_start;
      trig_oe && !trig_o;
   endsequence

   property p_cr_end;
      s_str_done |-> tx_data == CHAR_CR;
   endproperty
   a_cr_end: assert property (p_cr_end) else $error("Report did not end in CR");

   property p_addr_char;
      state == S_SEND && tx_hs && send_idx == IDX_ADDR |-> tx_data == own_addr;
   endproperty
   a_addr_char: assert property (p_addr_char) else $error("Report lacks own address");

   property p_trig_pulse;
      s_str_done |=> s_pulse_start ##1 trig_oe[*3];
   endproperty
   a_trig_pulse: assert property (p_trig_pulse) else $error("Trigger pulse missing");

   property p_trig_len;
      trig_oe && trig_cnt == '0 && !str_done |=> !trig_oe;
   endproperty
   a_trig_len: assert property (p_trig_len) else $error("Trigger pulse too long");

   property p_edge_delay;
      state == S_IDLE && mode_reg == MODE_EDGE && edge_rise && !ct_zero |=> state == S_DELAY && wait_cnt == $past(ct_reg);
   endproperty
   a_edge_delay: assert property (p_edge_delay) else $error("Edge trigger did not start delay");

   property p_no_fall_start;
      state == S_IDLE && mode_reg == MODE_EDGE && !edge_rise |=> state == S_IDLE;
   endproperty
   a_no_fall_start: assert property (p_no_fall_start) else $error("Report started without rise");

   property p_change_send;
      state == S_IDLE && mode_reg == MODE_CHANGE && in_changed |=> state == S_SEND ##1 tx_valid;
   endproperty
   a_change_send: assert property (p_change_send) else $error("Change not reported");

   property p_dead_time;
      s_str_done and (mode_reg == MODE_CHANGE && !ct_zero) |=> state == S_DEAD && wait_cnt == ct_reg;
   endproperty
   a_dead_time: assert property (p_dead_time) else $error("Dead time not entered");

   property p_inverted_out;
      rx_accept |=> io_out == ~$past(rx_word[LINES-1:0]);
   endproperty
   a_inverted_out: assert property (p_inverted_out) else $error("Output not inverted report");

   property p_cia_match;
      rx_valid && rx_ok && rx_idx == IDX_ADDR && rx_data != cia_reg && rx_data != CHAR_STAR |=> !rx_ok;
   endproperty
   a_cia_match: assert property (p_cia_match) else $error("Report accepted wrongly");
endmodule

// >>> rtl/report_pkg.sv
// Overview of operation
// - Trigger output feeds the next module's edge input; up to 123 edge modules.
// - Every autonomous report string ends with a carriage return.
// - Each report carries the sender's own bus address with the line data.
// - Edge mode waits the continuous timer after a trigger before reporting.
// - Change mode reports the new line states when any input line changes.
// - Change mode scans continuously and resumes after a report is fully sent.
// - Change mode with nonzero timer pauses that long after each report.
// - After disable the block idles; change enable command restarts change mode.
// - After disable the timer enable command restarts periodic reporting.
// - Input mode applies an accepted foreign report to the own output lines.
// - Shared change-mode buses use checksums so collision damage is detected.
// - Direction value 00ff makes lines 0-7 outputs and lines 8-14 inputs.
// - Periodic mode pulses the trigger output on each report.
// - After each string the trigger pin is driven low 5 ms, then released.
// - The edge trigger input starts a report on a rising edge only.
// - Input mode accepts a report only if its sender address equals the set code.
// - Received data bits are inverted before driving the output lines.
package report_pkg;
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_NS = 10_000_000;            // Timer unit: 10 ms
   localparam int TRIG_PULSE_NS = 5_000_000;       // Trigger low pulse: 5 ms
   localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
   localparam int TRIG_CYCLES = TRIG_PULSE_NS / CLK_PERIOD_NS;
   // Sizes
   localparam int DATA_W = 16;
   localparam int LINES_DEF = 15;
   // Register offsets
   localparam logic [7:0] REG_MODE = 8'h00;
   localparam logic [7:0] REG_TIMER = 8'h04;
   localparam logic [7:0] REG_ADDR = 8'h08;
   localparam logic [7:0] REG_DIR = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_RXCNT = 8'h14;
   // Reset values and fields
   localparam logic [15:0] TIMER_RESET = 16'h0000;
   localparam logic [7:0] OWN_ADDR_RESET = 8'h31;
   localparam logic [7:0] CIA_RESET = 8'h31;
   localparam logic [15:0] DIR_RESET = 16'h0000;
   // Responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Characters
   localparam logic [7:0] CHAR_STAR = 8'h2a;
   localparam logic [7:0] CHAR_D = 8'h44;
   localparam logic [7:0] CHAR_I = 8'h49;
   localparam logic [7:0] CHAR_CR = 8'h0d;
   localparam logic [7:0] CHAR_0 = 8'h30;
   localparam logic [7:0] CHAR_9 = 8'h39;
   localparam logic [7:0] CHAR_A = 8'h41;
   localparam logic [7:0] CHAR_F = 8'h46;
   localparam logic [7:0] HEX_LETTER_BASE = 8'h37;  // 'A' minus ten
   // Positions within a report string
   localparam logic [3:0] IDX_ADDR = 4'h1;
   localparam logic [3:0] IDX_CKS_HI = 4'h8;
   localparam logic [3:0] IDX_LAST = 4'ha;
   typedef enum logic [2:0] {
      MODE_OFF = 3'b000,
      MODE_TIMER = 3'b001,
      MODE_EDGE = 3'b010,
      MODE_CHANGE = 3'b011,
      MODE_INPUT = 3'b100
   } mode_t;
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_DELAY = 2'b01,
      S_SEND = 2'b10,
      S_DEAD = 2'b11
   } state_t;
endpackage

// >>> tb/serial_peer.sv
`timescale 1ns/1ps
module serial_peer (
   // Clock
   input wire logic ref_clk,
   // Report stream from the engine
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   // Character stream into the engine
   output logic [7:0] rx_data,
   output logic rx_valid,
   // Stall control
   input wire logic slow
);
   logic [7:0] got [$];
   logic phase = 1'b0;

   initial begin
      tx_ready = 1'b1;
      rx_data = 8'h00;
      rx_valid = 1'b0;
   end

   // Keep every character, garbage too; slow mode takes one every other cycle
   always @(posedge ref_clk) begin
      if (tx_valid && tx_ready) got.push_back(tx_data);
      phase <= ~phase;
      tx_ready <= !slow || phase;
   end

   // Send a string plus CR, one character a cycle, then scramble the idle data
   task automatic send(input string s);
      for (int i = 0; i <= s.len(); i++) begin
         rx_data <= (i < s.len()) ? 8'(s[i]) : 8'h0d;
         rx_valid <= 1'b1;
         @(posedge ref_clk);
      end
      rx_data <= 8'hf2;
      rx_valid <= 1'b0;
      @(posedge ref_clk);
   endtask
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top import report_pkg::*; ;
   localparam int TRIG_N = 8;
   logic ref_clk, resetn, slow, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, tx_valid, tx_ready, rx_valid;
   logic trig_o, trig_oe;
   logic [7:0] s_axi_awaddr, s_axi_araddr, tx_data, rx_data;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [14:0] io_in, io_out, io_oe;
   int fails = 0;
   int num_checks = 0;

   continuous_io_report_engine #(.TICK_CYC(10), .TRIG_CYC(TRIG_N)) continuous_io_report_engine_i (
      .ref_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .io_in, .io_out, .io_oe, .trig_o, .trig_oe);
   serial_peer serial_peer_i (.ref_clk, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .slow);

   // Clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Watchdog against a hang
   initial begin
      #500_000;
      fails++;
      wrap_up();
   end

   task automatic wrap_up;
      if (fails == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (aw && s_axi_awready) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk(32'(s_axi_bresp), 32'(er));
      @(posedge ref_clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic ar;
      ar = 1'b1;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (ar && s_axi_arready) begin
            ar = 1'b0;
            s_axi_arvalid <= 1'b0;
         end
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, e);
      chk(32'(s_axi_rresp), 32'(er));
      @(posedge ref_clk);
   endtask

   function automatic logic [7:0] hx(input logic [3:0] n);
      return (n < 4'ha) ? CHAR_0 + 8'(n) : HEX_LETTER_BASE + 8'(n);
   endfunction

   // Collect one report, compare it, then time the trigger pulse behind it
   task automatic get_report(input logic [15:0] w);
      logic [7:0] e [$];
      logic [7:0] sum;
      int n;
      e = {CHAR_STAR, 8'h31, CHAR_D, CHAR_I, hx(w[15:12]), hx(w[11:8]), hx(w[7:4]), hx(w[3:0])};
      sum = 8'h00;
      foreach (e[i]) sum += e[i];
      e.push_back(hx(sum[7:4]));
      e.push_back(hx(sum[3:0]));
      e.push_back(CHAR_CR);
      while (serial_peer_i.got.size() < 11) @(posedge ref_clk);
      foreach (e[i]) chk(32'(serial_peer_i.got[i]), 32'(e[i]));
      serial_peer_i.got.delete();
      n = 0;
      while (trig_oe !== 1'b1) @(posedge ref_clk);
      chk(32'(trig_o), 32'h0);
      while (trig_oe === 1'b1) begin
         n++;
         @(posedge ref_clk);
      end
      chk(32'(n), 32'(TRIG_N));
   endtask

   // Main sequence
   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, resetn, slow, io_in} = '0;
      s_axi_wstrb = 4'hf;
      repeat (10) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rd(REG_MODE, 32'h0, RESP_OKAY);
      rd(REG_ADDR, 32'h3131, RESP_OKAY);
      rd(REG_DIR, 32'h0, RESP_OKAY);
      rd(8'h40, 32'h0, RESP_SLVERR);
      wr(8'h40, 32'h1, RESP_SLVERR);
      wr(REG_DIR, 32'h00ff, RESP_OKAY);
      chk(32'(io_oe), 32'h00ff);
      // Timed report with the receiver stalling; period far longer than one string
      wr(REG_DIR, 32'h0, RESP_OKAY);
      io_in <= 15'h1234;
      slow <= 1'b1;
      wr(REG_TIMER, 32'd50, RESP_OKAY);
      wr(REG_MODE, 32'd1, RESP_OKAY);
      get_report(16'h1234);
      wr(REG_MODE, 32'd0, RESP_OKAY);
      rd(REG_MODE, 32'h0, RESP_OKAY);
      slow <= 1'b0;
      // Edge start with delay, falling edge ignored
      wr(REG_TIMER, 32'd2, RESP_OKAY);
      io_in <= 15'h0abe;
      wr(REG_MODE, 32'd2, RESP_OKAY);
      io_in <= 15'h0abf;
      repeat (10) @(posedge ref_clk);
      chk(32'(serial_peer_i.got.size()), 32'h0);
      get_report(16'h0abf);
      io_in <= 15'h0abe;
      repeat (60) @(posedge ref_clk);
      chk(32'(serial_peer_i.got.size()), 32'h0);
      rd(REG_STATUS, 32'h0abe, RESP_OKAY);
      // Unknown code disables; change reports, output lines ignored, dead time
      wr(REG_MODE, 32'd7, RESP_OKAY);
      rd(REG_MODE, 32'h0, RESP_OKAY);
      wr(REG_DIR, 32'h00ff, RESP_OKAY);
      wr(REG_TIMER, 32'd0, RESP_OKAY);
      io_in <= 15'h0100;
      wr(REG_MODE, 32'd3, RESP_OKAY);
      repeat (40) @(posedge ref_clk);
      serial_peer_i.got.delete();
      io_in <= 15'h0300;
      get_report(16'h0300);
      io_in <= 15'h0301;
      repeat (40) @(posedge ref_clk);
      chk(32'(serial_peer_i.got.size()), 32'h0);
      io_in <= 15'h0200;
      get_report(16'h0200);
      wr(REG_TIMER, 32'd5, RESP_OKAY);
      io_in <= 15'h0300;
      get_report(16'h0300);
      io_in <= 15'h0200;
      repeat (20) @(posedge ref_clk);
      chk(32'(serial_peer_i.got.size()), 32'h0);
      get_report(16'h0200);
      // Foreign reports driving the outputs; checksum is the low byte of the sum
      wr(REG_DIR, 32'h7fff, RESP_OKAY);
      wr(REG_MODE, 32'd4, RESP_OKAY);
      serial_peer_i.send("*1DIA0A0CA");
      repeat (3) @(posedge ref_clk);
      chk(32'(io_out), 32'h5f5f);
      serial_peer_i.send("*2DI0000A9");
      serial_peer_i.send("*1DI0000A9");
      repeat (3) @(posedge ref_clk);
      chk(32'(io_out), 32'h5f5f);
      serial_peer_i.send("*1DI0000A8");
      repeat (3) @(posedge ref_clk);
      chk(32'(io_out), 32'h7fff);
      rd(REG_RXCNT, 32'd2, RESP_OKAY);
      wrap_up();
   end
endmodule
